/* core/sfcfe_pkg.sv */
package sfcfe_pkg;

    // opcodes
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_DUAL_READ = 8'h3b;
    localparam logic [7:0] OP_QUAD_READ = 8'heb;
    localparam logic [7:0] OP_ALGN_READ = 8'he7;
    localparam logic [7:0] OP_ERASE_4K  = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;

    // phase lengths in link clocks
    localparam logic [4:0] OPCODE_CLKS   = 5'h08;
    localparam logic [4:0] ADDR_CLKS_X1  = 5'h18;
    localparam logic [4:0] ADDR_CLKS_X4  = 5'h06;
    localparam logic [4:0] DUMMY_CLKS_X1 = 5'h08;
    localparam logic [4:0] DC_BASE_CLKS  = 5'h02;
    localparam int         ARRAY_AW      = 20;
    localparam int         ALIGN_BITS    = 2;
    localparam logic [8:0] PAGE_MAX      = 9'h100;
    localparam int         DATA_CNT_W    = 9;

    // reset values
    localparam logic [1:0] SYNC_RST      = 2'h0;
    localparam logic [7:0] BYTE_RST      = 8'h00;

    typedef enum logic [3:0] {
        SFCFE_NONE, SFCFE_RD, SFCFE_FRD, SFCFE_DRD, SFCFE_QRD, SFCFE_ARD,
        SFCFE_ER4, SFCFE_ER32, SFCFE_ER64, SFCFE_PP, SFCFE_WREN, SFCFE_WRDI
    } sfcfe_op_t;

    typedef struct packed {
        sfcfe_op_t             op;
        logic [ARRAY_AW-1:0]   addr;
        logic [DATA_CNT_W-1:0] nbytes;
    } sfcfe_cmd_t;

    typedef struct packed {
        logic                  continuous_read_mode;
        logic                  quad_enable;
        logic                  aligned_addr_mode;
        logic [2:0]            dummy_clock_count;
    } sfcfe_cfg_t;

endpackage

/* core/sfcfe_pin_sync.sv */
module sfcfe_pin_sync
    import sfcfe_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // raw and synced pins
    input  wire logic [6:0] din,
    output logic      [6:0] dout
);

    logic [6:0] s1_ff;
    logic [6:0] s2_ff;

    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_ff[i] <= (i == 0) ? 1'b1 : 1'b0;
                    s2_ff[i] <= (i == 0) ? 1'b1 : 1'b0;
                end else begin
                    s1_ff[i] <= din[i];
                    s2_ff[i] <= s1_ff[i];
                end
            end
        end
    endgenerate

    assign dout = s2_ff;

endmodule

/* core/sfcfe_front_end.sv */
module sfcfe_front_end
    import sfcfe_pkg::*;
(
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    // serial link
    input  wire logic             CS_N,
    input  wire logic             SCK,
    input  wire logic [3:0]       IO_IN,
    output logic      [3:0]       IO_OUT,
    output logic      [3:0]       IO_OE,
    // configuration
    input  wire logic             CONTINUOUS_READ_MODE,
    input  wire logic             QUAD_ENABLE,
    input  wire logic             ALIGNED_ADDR_MODE,
    input  wire logic [2:0]       DUMMY_CLOCK_COUNT,
    // array read data
    input  wire logic [7:0]       RD_DATA,
    // decoded command
    output sfcfe_cmd_t            CMD,
    output logic                  CMD_VALID,
    output logic                  RD_REQ,
    output logic [ARRAY_AW-1:0]   RD_ADDR,
    output logic [7:0]            WR_DATA,
    output logic                  WR_VALID,
    output logic                  CONT_MODE_ACTIVE
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_DONE, ST_IGNORE
    } sfcfe_state_t;

    logic [6:0] sync_w;
    logic       cs_n_s, sck_s, sck_d_ff;
    logic [3:0] io_s;
    logic       rise, fall;

    sfcfe_pin_sync u_sync (
        .clk    (CLK),
        .arst_n (ARST_N),
        .din    ({IO_IN, SCK, 1'b0, CS_N} ),
        .dout   (sync_w)
    );
    assign cs_n_s = sync_w[0];
    assign sck_s  = sync_w[2];
    assign io_s   = sync_w[6:3];
    assign rise   = sck_s && !sck_d_ff && !cs_n_s;
    assign fall   = !sck_s && sck_d_ff && !cs_n_s;

    sfcfe_state_t state_ff;
    sfcfe_op_t    op_ff, nxt_op;
    logic [23:0]  sh_ff;
    logic [4:0]   cnt_ff;
    logic [2:0]   bit_ff;
    logic [8:0]   nbyte_ff;
    logic         cont_ff;
    logic         cs_d_ff;
    logic [7:0]   obyte_ff;
    logic [2:0]   width;
    logic [4:0]   dc_clks;
    logic [ARRAY_AW-1:0] addr_w;
    logic [23:0]  sh_nxt;

    assign dc_clks = DC_BASE_CLKS + {1'b0, DUMMY_CLOCK_COUNT, 1'b0};
    assign width = (op_ff == SFCFE_QRD || op_ff == SFCFE_ARD) ? 3'h4 :
                   (op_ff == SFCFE_DRD) ? 3'h2 : 3'h1;

    always_comb begin
        case (state_ff == ST_OPC ? 3'h1 : width)
            3'h4:    sh_nxt = {sh_ff[19:0], io_s};
            3'h2:    sh_nxt = {sh_ff[21:0], io_s[1:0]};
            default: sh_nxt = {sh_ff[22:0], io_s[0]};
        endcase
    end

    assign addr_w = (op_ff == SFCFE_ARD && ALIGNED_ADDR_MODE) ?
                    {sh_nxt[ARRAY_AW-1:ALIGN_BITS], 2'h0} : sh_nxt[ARRAY_AW-1:0];

    always_comb begin
        case (sh_nxt[7:0])
            OP_READ:      nxt_op = SFCFE_RD;
            OP_FAST_READ: nxt_op = SFCFE_FRD;
            OP_DUAL_READ: nxt_op = SFCFE_DRD;
            OP_QUAD_READ: nxt_op = SFCFE_QRD;
            OP_ALGN_READ: nxt_op = SFCFE_ARD;
            OP_ERASE_4K:  nxt_op = SFCFE_ER4;
            OP_ERASE_32K: nxt_op = SFCFE_ER32;
            OP_ERASE_64K: nxt_op = SFCFE_ER64;
            OP_PAGE_PROG: nxt_op = SFCFE_PP;
            OP_WR_EN:     nxt_op = SFCFE_WREN;
            OP_WR_DIS:    nxt_op = SFCFE_WRDI;
            default:      nxt_op = SFCFE_NONE;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else begin
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_n_s;
        end
    end

    // frame state machine
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff  <= ST_IDLE;
            op_ff     <= SFCFE_NONE;
            sh_ff     <= 24'h000000;
            cnt_ff    <= 5'h00;
            bit_ff    <= 3'h0;
            nbyte_ff  <= 9'h000;
            cont_ff   <= 1'b0;
            CMD       <= '0;
            CMD_VALID <= 1'b0;
            RD_REQ    <= 1'b0;
            RD_ADDR   <= '0;
            WR_DATA   <= BYTE_RST;
            WR_VALID  <= 1'b0;
            CONT_MODE_ACTIVE <= 1'b0;
        end else begin
            CMD_VALID <= 1'b0;
            RD_REQ    <= 1'b0;
            WR_VALID  <= 1'b0;
            if (!CONTINUOUS_READ_MODE || !QUAD_ENABLE) begin
                cont_ff <= 1'b0;
            end
            CONT_MODE_ACTIVE <= cont_ff;
            if (cs_n_s) begin
                if (state_ff == ST_WDATA && nbyte_ff != 9'h000) begin
                    CMD       <= '{op: SFCFE_PP, addr: RD_ADDR, nbytes: nbyte_ff};
                    CMD_VALID <= 1'b1;
                end
                state_ff <= ST_IDLE;
            end else if (cs_d_ff) begin
                sh_ff    <= 24'h000000;
                nbyte_ff <= 9'h000;
                if (cont_ff) begin
                    state_ff <= ST_ADDR;
                    cnt_ff   <= ADDR_CLKS_X4;
                end else begin
                    state_ff <= ST_OPC;
                    cnt_ff   <= OPCODE_CLKS;
                end
            end else if (rise) begin
                case (state_ff)
                    ST_OPC: begin
                        sh_ff  <= sh_nxt;
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            op_ff <= nxt_op;
                            sh_ff <= 24'h000000;
                            if (nxt_op == SFCFE_NONE) begin
                                state_ff <= ST_IGNORE;
                            end else if (nxt_op == SFCFE_WREN || nxt_op == SFCFE_WRDI) begin
                                CMD       <= '{op: nxt_op, addr: '0, nbytes: '0};
                                CMD_VALID <= 1'b1;
                                state_ff  <= ST_DONE;
                            end else begin
                                state_ff <= ST_ADDR;
                                cnt_ff   <= (nxt_op == SFCFE_QRD || nxt_op == SFCFE_ARD) ?
                                            ADDR_CLKS_X4 : ADDR_CLKS_X1;
                            end
                        end
                    end
                    ST_ADDR: begin
                        sh_ff  <= (width == 3'h4) ? {sh_ff[19:0], io_s} : {sh_ff[22:0], io_s[0]};
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            RD_ADDR <= (width == 3'h4) ? addr_w :
                                       {sh_ff[ARRAY_AW-2:0], io_s[0]};
                            bit_ff  <= 3'h0;
                            case (op_ff)
                                SFCFE_RD: begin
                                    state_ff <= ST_RDATA;
                                    RD_REQ   <= 1'b1;
                                end
                                SFCFE_PP:   state_ff <= ST_WDATA;
                                SFCFE_ER4, SFCFE_ER32, SFCFE_ER64: begin
                                    CMD       <= '{op: op_ff,
                                                   addr: {sh_ff[ARRAY_AW-2:0], io_s[0]},
                                                   nbytes: '0};
                                    CMD_VALID <= 1'b1;
                                    state_ff  <= ST_DONE;
                                end
                                SFCFE_QRD, SFCFE_ARD: begin
                                    state_ff <= ST_DUMMY;
                                    cnt_ff   <= dc_clks;
                                end
                                default: begin
                                    state_ff <= ST_DUMMY;
                                    cnt_ff   <= DUMMY_CLKS_X1;
                                end
                            endcase
                        end
                    end
                    ST_DUMMY: begin
                        cnt_ff <= cnt_ff - 5'h01;
                        // first dummy clock: CONTINUOUS_READ_MODE and QUAD_ENABLE keep continuous read armed
                        if ((op_ff == SFCFE_QRD || op_ff == SFCFE_ARD)
                            && cnt_ff == dc_clks) begin
                            cont_ff <= CONTINUOUS_READ_MODE && QUAD_ENABLE;
                        end
                        if (cnt_ff == 5'h01) begin
                            state_ff <= ST_RDATA;
                            RD_REQ   <= 1'b1;
                        end
                    end
                    ST_WDATA: begin
                        sh_ff  <= sh_nxt;
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7 && nbyte_ff != PAGE_MAX) begin
                            WR_DATA  <= sh_nxt[7:0];
                            WR_VALID <= 1'b1;
                            nbyte_ff <= nbyte_ff + 9'h001;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (fall && state_ff == ST_RDATA) begin
                bit_ff <= bit_ff + width;
                if (bit_ff + width == 3'h0 || (width == 3'h4 && bit_ff == 3'h4)) begin
                    RD_ADDR <= RD_ADDR + 20'h00001;
                    RD_REQ  <= 1'b1;
                end
            end
        end
    end

    // output shifter, msb first on the lanes in use
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            obyte_ff <= BYTE_RST;
            IO_OUT   <= 4'h0;
            IO_OE    <= 4'h0;
        end else if (state_ff != ST_RDATA || cs_n_s) begin
            IO_OE  <= 4'h0;
            IO_OUT <= 4'h0;
        end else begin
            if (RD_REQ) begin
                obyte_ff <= RD_DATA;
            end
            if (fall) begin
                case (width)
                    3'h4: begin
                        IO_OUT <= bit_ff[2] ? obyte_ff[3:0] : RD_DATA[7:4];
                        IO_OE  <= 4'hf;
                    end
                    3'h2: begin
                        IO_OUT <= {2'h0, RD_DATA[3'h7 - bit_ff -: 2]};
                        IO_OE  <= 4'h3;
                    end
                    default: begin
                        IO_OUT <= {2'h0, RD_DATA[3'h7 - bit_ff], 1'b0};
                        IO_OE  <= 4'h2;
                    end
                endcase
            end
        end
    end

endmodule

/* test/sfcfe_front_end_monitor.sv */
module sfcfe_front_end_monitor
    import sfcfe_pkg::*;
(
    // clock, reset, link
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       CS_N,
    input  wire logic [3:0] IO_OE,
    // configuration
    input  wire logic       CONTINUOUS_READ_MODE,
    input  wire logic       QUAD_ENABLE,
    input  wire logic       ALIGNED_ADDR_MODE,
    // decoded outputs
    input  wire sfcfe_cmd_t CMD,
    input  wire logic       CMD_VALID,
    input  wire logic       RD_REQ,
    input  wire logic [ARRAY_AW-1:0] RD_ADDR,
    input  wire logic       WR_VALID,
    input  wire logic       CONT_MODE_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_oe_idle: assert property (CS_N [*6] |-> IO_OE == 4'h0)
        else $error("lanes driven while deselected");
    a_oe_shape: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("bad lane enable pattern");
    a_cmd_pulse: assert property (CMD_VALID |=> !CMD_VALID)
        else $error("command strobe too long");
    a_cmd_known: assert property (CMD_VALID |-> CMD.op != SFCFE_NONE)
        else $error("strobe with no operation");
    a_rdreq_gap: assert property (RD_REQ |=> !RD_REQ [*4])
        else $error("read requests too close");
    a_cont_gate: assert property ((!QUAD_ENABLE || !CONTINUOUS_READ_MODE) [*4]
        |-> !CONT_MODE_ACTIVE)
        else $error("continuous mode without enables");
    a_idle_quiet: assert property (CS_N [*8] |-> !RD_REQ && !WR_VALID)
        else $error("activity while deselected");
    // first fetch of a frame: lanes still released
    a_align_zero: assert property (RD_REQ && IO_OE == 4'h0 && ALIGNED_ADDR_MODE
        |-> RD_ADDR[1:0] == 2'h0)
        else $error("aligned address not cleared");
endmodule

bind sfcfe_front_end sfcfe_front_end_monitor u_sfcfe_front_end_monitor (
    .CLK                  (CLK),
    .ARST_N               (ARST_N),
    .CS_N                 (CS_N),
    .IO_OE                (IO_OE),
    .CONTINUOUS_READ_MODE (CONTINUOUS_READ_MODE),
    .QUAD_ENABLE          (QUAD_ENABLE),
    .ALIGNED_ADDR_MODE    (ALIGNED_ADDR_MODE),
    .CMD                  (CMD),
    .CMD_VALID            (CMD_VALID),
    .RD_REQ               (RD_REQ),
    .RD_ADDR              (RD_ADDR),
    .WR_VALID             (WR_VALID),
    .CONT_MODE_ACTIVE     (CONT_MODE_ACTIVE)
);

/* test/sfcfe_host_model.sv */
module sfcfe_host_model (
    // clock
    input  wire logic       clk,
    // link
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drv;
    logic [3:0] hoe;
    logic       flip;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        drv = 4'h0;
        hoe = 4'h0;
        flip = 1'b0;
    end
    always @(posedge clk) flip <= ~flip;
    // wire level: device, else host, else toggling
    assign io_in = (io_oe & io_out) | (~io_oe & hoe & drv) | (~io_oe & ~hoe & {4{flip}});

    task automatic half();
        repeat (10) @(posedge clk);
    endtask
    // select before clocking, release ends frame
    task automatic sel(input logic on);
        half();
        cs_n <= ~on;
        hoe <= 4'h0;
        half();
    endtask
    task automatic put(input logic [31:0] v, input int n, input int w);
        logic [31:0] m = (32'h1 << w) - 32'h1;
        for (int i = n - 1; i >= 0; i--) begin
            drv <= 4'((v >> (i * w)) & m);
            hoe <= 4'(m);
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
        end
    endtask
    task automatic get(input int n, input int w, output logic [15:0] d);
        logic [3:0] m = 4'((32'h1 << w) - 32'h1);
        d = 16'h0;
        hoe <= 4'h0;
        for (int i = 0; i < n; i++) begin
            half();
            sck <= 1'b1;
            d = (d << w) | 16'((w == 1) ? {3'h0, io_in[1]} : io_in & m);
            half();
            sck <= 1'b0;
        end
    endtask
endmodule

/* test/tb_sfcfe_front_end.sv */
module tb_sfcfe_front_end
    import sfcfe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, cs_n, sck, crm, qe, aam, cmd_valid, rd_req, wr_valid, cont;
    logic [3:0] io_in, io_out, io_oe;
    logic [2:0] dcc;
    logic [7:0] rd_data, wr_data;
    logic [ARRAY_AW-1:0] rd_addr;
    sfcfe_cmd_t cmd, last_cmd;
    int cmd_cnt = 0;
    int cycles = 0;
    int bad_count = 0;
    int samples_checked = 0;
    logic [7:0] wq[$];

    sfcfe_front_end u_sfcfe_front_end (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n), .SCK(sck),
        .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .CONTINUOUS_READ_MODE(crm),
        .QUAD_ENABLE(qe), .ALIGNED_ADDR_MODE(aam), .DUMMY_CLOCK_COUNT(dcc), .RD_DATA(rd_data),
        .CMD(cmd), .CMD_VALID(cmd_valid), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
        .WR_DATA(wr_data), .WR_VALID(wr_valid), .CONT_MODE_ACTIVE(cont));
    sfcfe_host_model u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));

    function automatic logic [7:0] mem(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction
    assign rd_data = mem(rd_addr[7:0]);
    always @(posedge clk) if (cmd_valid === 1'b1) begin
        last_cmd <= cmd;
        cmd_cnt <= cmd_cnt + 1;
    end
    always @(posedge clk) if (wr_valid === 1'b1) wq.push_back(wr_data);

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic t_simple();
        logic [7:0] opc [5] = '{8'h20, 8'h52, 8'hd8, 8'h06, 8'h04};
        sfcfe_op_t exo [5] = '{SFCFE_ER4, SFCFE_ER32, SFCFE_ER64, SFCFE_WREN, SFCFE_WRDI};
        int n;
        for (int i = 0; i < 5; i++) begin
            n = cmd_cnt;
            u_host.sel(1'b1);
            u_host.put(32'(opc[i]), 8, 1);
            if (i < 3) u_host.put(32'hf12345, 24, 1);
            u_host.sel(1'b0);
            chk(40'(cmd_cnt - n), 40'h1);
            chk(40'(last_cmd.op), 40'(exo[i]));
            if (i < 3) chk(40'(last_cmd.addr), 40'h12345);
        end
    endtask
    task automatic t_refuse();
        int n = cmd_cnt;
        u_host.sel(1'b1);
        u_host.put(32'h9f, 8, 1);
        u_host.put(32'h20012345, 32, 1);
        u_host.sel(1'b0);
        u_host.sel(1'b1);
        u_host.put(32'h200123, 24, 1);
        u_host.sel(1'b0);
        chk(40'(cmd_cnt - n), 40'h0);
    endtask
    task automatic t_read();
        logic [7:0] opc [3] = '{8'h03, 8'h0b, 8'h3b};
        logic [15:0] d;
        for (int i = 0; i < 3; i++) begin
            u_host.sel(1'b1);
            u_host.put({opc[i], 24'h3000fe}, 32, 1);
            if (i > 0) u_host.put(32'h0, 8, 1);
            u_host.get(i == 2 ? 8 : 16, i == 2 ? 2 : 1, d);
            u_host.sel(1'b0);
            chk(40'(d), {24'h0, mem(8'hfe), mem(8'hff)});
        end
    endtask
    task automatic t_prog();
        wq.delete();
        u_host.sel(1'b1);
        u_host.put(32'h02054321, 32, 1);
        u_host.put(32'ha5c3, 16, 1);
        u_host.put(32'h1, 3, 1);
        u_host.sel(1'b0);
        chk(40'(wq.size()), 40'h2);
        chk({24'h0, wq[0], wq[1]}, 40'ha5c3);
        chk(40'(last_cmd), {7'h0, SFCFE_PP, 20'h54321, 9'h002});
    endtask
    task automatic t_quad();
        logic [15:0] d;
        crm <= 1'b1;
        qe <= 1'b1;
        dcc <= 3'h1;
        for (int i = 0; i < 2; i++) begin
            u_host.sel(1'b1);
            if (i == 0) u_host.put(32'heb, 8, 1);
            u_host.put(32'h0abc10, 6, 4);
            u_host.put(32'h0, 4, 4);
            u_host.get(4, 4, d);
            u_host.sel(1'b0);
            chk(40'(d), {24'h0, mem(8'h10), mem(8'h11)});
            chk(40'(cont), 40'h1);
        end
        qe <= 1'b0;
        repeat (8) @(posedge clk);
        chk(40'(cont), 40'h0);
        crm <= 1'b0;
        qe <= 1'b1;
        aam <= 1'b1;
        dcc <= 3'h2;
        u_host.sel(1'b1);
        u_host.put(32'he7, 8, 1);
        u_host.put(32'h0abc17, 6, 4);
        u_host.put(32'h0, 6, 4);
        u_host.get(4, 4, d);
        u_host.sel(1'b0);
        chk(40'(d), {24'h0, mem(8'h14), mem(8'h15)});
        chk(40'(cont), 40'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        arst_n = 1'b0;
        crm = 1'b0;
        qe = 1'b0;
        aam = 1'b0;
        dcc = 3'h0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_refuse();
        t_simple();
        t_read();
        t_prog();
        t_quad();
        end_sim();
    end
endmodule
